//--- hw/pcra_regs_aux.sv
// Purpose: Register bank of a frequency synthesizer with open-style serial access and auxiliary serial port
// Assumes: Serial clock stands still outside frames; word is stable while the select strobe is high
// Notes:   Serial shifting runs on serialClk; registers and auxiliary port run on ref_clk
`timescale 1ns/10ps

module pcra_regs_aux
    import pcra_pkg::*;
#(
    parameter logic [23:0] ID_WORD   = 24'h5A3C01, // Arbitrary identification value
    parameter logic [2:0]  CHIP_ADDR = 3'h0,
    parameter int          SYNC_N    = 5
) (
    input  wire logic                       ref_clk,
    input  wire logic                       rst_n,
    input  wire logic                       serialClk,
    input  wire logic                       serialDataIn,
    input  wire logic                       serialSelectStrobe,
    output logic                            lockStatusSerialOut,
    output logic                            lockStatusSerialOutOe,
    input  wire logic                       lockDetectIn,
    input  wire logic                       externalEnablePin,
    input  wire logic                       pfdClk,
    output logic                            auxSerialClk,
    output logic                            auxiliaryDataPin,
    output logic                            auxSerialStrobe,
    output logic                            chipEnable,
    output logic [pcra_pkg::KEEP_COUNT-1:0] blockPowered,
    output logic [13:0]                     refDivide,
    output logic [18:0]                     intDivide,
    output logic [23:0]                     fracDivide
);
    import pcra_pkg::*;

    // ************************************************************
    // Link side: shifting on the serial clock
    // ************************************************************
    logic [WORD_BITS-1:0] shiftIn_q;
    logic [22:0]          readShift_q;
    logic                 readActive_q;
    logic                 readBit_q;
    logic [23:0]          readWord_q;
    wire                  linkClr_n = rst_n & ~serialSelectStrobe;

    always_ff @(posedge serialClk or negedge rst_n) begin
        if (!rst_n) begin
            shiftIn_q <= '0;
        end else begin
            shiftIn_q <= {shiftIn_q[WORD_BITS-2:0], serialDataIn};
        end
    end

    // Cleared by the strobe itself, since the serial clock stops after the frame
    always_ff @(posedge serialClk or negedge linkClr_n) begin
        if (!linkClr_n) begin
            readActive_q <= 1'b0;
            readBit_q    <= 1'b0;
            readShift_q  <= '0;
        end else if (!readActive_q) begin
            readActive_q <= 1'b1;
            readBit_q    <= readWord_q[23];
            readShift_q  <= readWord_q[22:0];
        end else begin
            readBit_q    <= readShift_q[22];
            readShift_q  <= {readShift_q[21:0], 1'b0};
        end
    end

    // ************************************************************
    // Input synchronisers, a change counts when stages two and three agree
    // ************************************************************
    logic [SYNC_N-1:0] syncRaw;
    logic [SYNC_N-1:0] sync1_q;
    logic [SYNC_N-1:0] sync2_q;
    logic [SYNC_N-1:0] sync3_q;
    logic [SYNC_N-1:0] stable_q;

    assign syncRaw = {readBit_q, readActive_q, pfdClk, externalEnablePin, serialSelectStrobe};

    genvar gi;
    generate
        for (gi = 0; gi < SYNC_N; gi++) begin : gSync
            always_ff @(posedge ref_clk or negedge rst_n) begin
                if (!rst_n) begin
                    sync1_q[gi]  <= 1'b0;
                    sync2_q[gi]  <= 1'b0;
                    sync3_q[gi]  <= 1'b0;
                    stable_q[gi] <= 1'b0;
                end else begin
                    sync1_q[gi]  <= syncRaw[gi];
                    sync2_q[gi]  <= sync1_q[gi];
                    sync3_q[gi]  <= sync2_q[gi];
                    stable_q[gi] <= (sync2_q[gi] == sync3_q[gi]) ? sync3_q[gi] : stable_q[gi];
                end
            end
        end
    endgenerate

    logic strobeSeen_q;
    logic pfdSeen_q;
    wire  strobeLevel  = stable_q[0];
    wire  cenLevel     = stable_q[1];
    wire  pfdLevel     = stable_q[2];
    wire  readActSync  = stable_q[3];
    wire  readBitSync  = stable_q[4];
    wire  strobeRise   = strobeLevel & ~strobeSeen_q;
    wire  pfdRise      = pfdLevel & ~pfdSeen_q;
    wire  pfdFall      = ~pfdLevel & pfdSeen_q;

    // ************************************************************
    // Commit decode; the shifted word is still while the strobe is high
    // ************************************************************
    wire [23:0] wrData    = shiftIn_q[WORD_BITS-1:DATA_LSB];
    wire [4:0]  wrAddr    = shiftIn_q[ADDR_MSB:ADDR_LSB];
    wire        commit    = strobeRise & (shiftIn_q[CHIP_MSB:0] == CHIP_ADDR);
    wire        wrReg0    = commit & (wrAddr == OFS_ID_PTR);
    wire        softReset = wrReg0 & wrData[SWRST_BIT];
    wire        wrPtr     = wrReg0 & ~wrData[SWRST_BIT];
    wire        wrPower   = commit & (wrAddr == OFS_POWER);
    wire        wrRefDiv  = commit & (wrAddr == OFS_REFDIV);
    wire        wrIntDiv  = commit & (wrAddr == OFS_INTDIV);
    wire        wrFracDiv = commit & (wrAddr == OFS_FRACDIV);
    wire        wrAuxWord = commit & (wrAddr == OFS_AUXWORD);
    wire        freqCmd   = wrIntDiv | wrFracDiv;

    // ************************************************************
    // Register storage
    // ************************************************************
    logic [4:0]  readPtr_q;
    logic [8:0]  power_q;
    logic [15:0] auxWord_q;

    // Reset bit is decoded, never held
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            readPtr_q  <= RST_READPTR;
            power_q    <= RST_POWER;
            refDivide  <= RST_REFDIV;
            intDivide  <= RST_INTDIV;
            fracDivide <= RST_FRACDIV;
            auxWord_q  <= RST_AUXWORD;
        end else if (softReset) begin
            readPtr_q  <= RST_READPTR;
            power_q    <= RST_POWER;
            refDivide  <= RST_REFDIV;
            intDivide  <= RST_INTDIV;
            fracDivide <= RST_FRACDIV;
            auxWord_q  <= RST_AUXWORD;
        end else begin
            if (wrPtr)     readPtr_q  <= wrData[4:0];
            if (wrPower)   power_q    <= wrData[8:0];
            if (wrRefDiv)  refDivide  <= wrData[13:0];
            if (wrIntDiv)  intDivide  <= wrData[18:0];
            if (wrFracDiv) fracDivide <= wrData[23:0];
            if (wrAuxWord) auxWord_q  <= wrData[15:0];
        end
    end

    function automatic logic [23:0] regRead(input logic [4:0] a);
        unique case (a)
            OFS_ID_PTR:  regRead = ID_WORD;
            OFS_POWER:   regRead = {15'h0000, power_q};
            OFS_REFDIV:  regRead = {10'h000, refDivide};
            OFS_INTDIV:  regRead = {5'h00, intDivide};
            OFS_FRACDIV: regRead = fracDivide;
            OFS_AUXWORD: regRead = {8'h00, auxWord_q};
            default:     regRead = 24'h000000;
        endcase
    endfunction

    // ************************************************************
    // Read word, serial output and power control
    // ************************************************************
    wire                  enableNext = power_q[PWR_PIN_SEL] ? cenLevel : power_q[PWR_SPI_EN];
    wire [KEEP_COUNT-1:0] keepBits   = power_q[PWR_KEEP_LSB +: KEEP_COUNT];

    // Read word only changes at a commit, when the serial clock is stopped
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            readWord_q            <= 24'h000000;
            strobeSeen_q          <= 1'b0;
            pfdSeen_q             <= 1'b0;
            lockStatusSerialOut   <= 1'b0;
            lockStatusSerialOutOe <= 1'b0;
            chipEnable            <= 1'b0;
            blockPowered          <= '0;
        end else begin
            readWord_q            <= regRead(readPtr_q);
            strobeSeen_q          <= strobeLevel;
            pfdSeen_q             <= pfdLevel;
            lockStatusSerialOut   <= readActSync ? readBitSync : lockDetectIn;
            lockStatusSerialOutOe <= 1'b1;
            chipEnable            <= enableNext;
            blockPowered          <= keepBits | {KEEP_COUNT{enableNext}};
        end
    end

    // ************************************************************
    // Auxiliary serial port
    // ************************************************************
    pcra_aux_state_t auxState_q;
    logic [4:0]      auxCnt_q;
    logic [15:0]     auxShift_q;
    logic            auxPending_q;
    logic            auxGate_q;

    wire leadDone = (auxCnt_q == 5'(AUX_LEAD_CYC - 1));
    wire dataDone = (auxCnt_q == 5'(AUX_DATA_CYC - 1));
    wire tailDone = (auxCnt_q == 5'(AUX_TAIL_CYC - 1));

    // Set wins over the clear when a new command lands on the start cycle
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            auxPending_q <= 1'b0;
        end else if (softReset) begin
            auxPending_q <= 1'b0;
        end else if (freqCmd) begin
            auxPending_q <= 1'b1;
        end else if (auxState_q == AUX_IDLE) begin
            auxPending_q <= 1'b0;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            auxState_q <= AUX_IDLE;
            auxCnt_q   <= '0;
            auxShift_q <= '0;
        end else if (softReset) begin
            auxState_q <= AUX_IDLE;
            auxCnt_q   <= '0;
        end else begin
            unique case (auxState_q)
                AUX_IDLE: if (auxPending_q) begin
                    auxState_q <= AUX_LEAD;
                    auxCnt_q   <= '0;
                    auxShift_q <= auxWord_q;
                end
                AUX_LEAD: if (pfdRise) begin
                    auxCnt_q   <= leadDone ? 5'h00 : auxCnt_q + 5'h01;
                    auxState_q <= leadDone ? AUX_DATA : AUX_LEAD;
                end
                AUX_DATA: if (pfdRise) begin
                    auxCnt_q   <= dataDone ? 5'h00 : auxCnt_q + 5'h01;
                    auxState_q <= dataDone ? AUX_TAIL : AUX_DATA;
                    auxShift_q <= {auxShift_q[14:0], 1'b0};
                end
                AUX_TAIL: if (pfdRise) begin
                    auxCnt_q   <= tailDone ? 5'h00 : auxCnt_q + 5'h01;
                    auxState_q <= tailDone ? AUX_IDLE : AUX_TAIL;
                end
            endcase
        end
    end

    // Data moves on falling phase so the outgoing clock rises on stable data
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            auxGate_q        <= 1'b0;
            auxiliaryDataPin <= 1'b0;
            auxSerialStrobe  <= 1'b0;
            auxSerialClk     <= 1'b0;
        end else begin
            if (pfdFall && auxState_q == AUX_DATA) begin
                auxGate_q        <= 1'b1;
                auxiliaryDataPin <= auxShift_q[15];
            end else if (auxState_q == AUX_IDLE || (pfdFall && auxState_q == AUX_TAIL)) begin
                auxGate_q        <= 1'b0;
            end
            if (pfdFall && auxState_q == AUX_TAIL && auxCnt_q == 5'h00) begin
                auxSerialStrobe  <= 1'b1;
            end else if (pfdRise || auxState_q == AUX_IDLE) begin
                auxSerialStrobe  <= 1'b0;
            end
            auxSerialClk <= auxGate_q & pfdLevel;
        end
    end

    // ************************************************************
    // Checks
    // ************************************************************
    logic [5:0] auxTicks_q;
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            auxTicks_q <= '0;
        end else if (auxState_q == AUX_IDLE) begin
            auxTicks_q <= '0;
        end else if (pfdRise) begin
            auxTicks_q <= auxTicks_q + 6'h01;
        end
    end

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);

    property p_sdo_lock;
        !readActSync |=> lockStatusSerialOut == $past(lockDetectIn);
    endproperty
    a_sdo_lock: assert property (p_sdo_lock) else $error("serial out not lock status");

    property p_aux_start;
        (auxState_q == AUX_IDLE && auxPending_q && !softReset) |=>
            auxState_q == AUX_LEAD ##0 auxShift_q == $past(auxWord_q);
    endproperty
    a_aux_start: assert property (p_aux_start) else $error("aux transfer did not start");

    property p_aux_len;
        (auxState_q != AUX_IDLE && !softReset) ##1 auxState_q == AUX_IDLE |->
            $past(auxTicks_q) == 6'(AUX_TOTAL_CYC - 1);
    endproperty
    a_aux_len: assert property (p_aux_len) else $error("aux transfer not twenty cycles");

    property p_id_read;
        readPtr_q == OFS_ID_PTR |=> readWord_q == ID_WORD;
    endproperty
    a_id_read: assert property (p_id_read) else $error("identification word wrong");

    property p_soft_reset;
        softReset |=> refDivide == RST_REFDIV && intDivide == RST_INTDIV
            && power_q == RST_POWER && auxWord_q == RST_AUXWORD;
    endproperty
    a_soft_reset: assert property (p_soft_reset) else $error("soft reset left registers");

    property p_read_ptr;
        wrPtr |=> readPtr_q == $past(wrData[4:0]) ##1 readWord_q == regRead(readPtr_q);
    endproperty
    a_read_ptr: assert property (p_read_ptr) else $error("read pointer not taken");

    property p_pin_enable;
        power_q[PWR_PIN_SEL] |=> chipEnable == $past(cenLevel);
    endproperty
    a_pin_enable: assert property (p_pin_enable) else $error("chip enable not following pin");

    property p_spi_enable;
        !power_q[PWR_PIN_SEL] |=> chipEnable == $past(power_q[PWR_SPI_EN]);
    endproperty
    a_spi_enable: assert property (p_spi_enable) else $error("chip enable not following bit");

    property p_keep_on;
        power_q[PWR_KEEP_LSB] |=> blockPowered[0];
    endproperty
    a_keep_on: assert property (p_keep_on) else $error("bias kept off");

    property p_frac_write;
        (wrFracDiv && !softReset) |=> fracDivide == $past(wrData);
    endproperty
    a_frac_write: assert property (p_frac_write) else $error("fraction not stored");

endmodule

//--- hw/pcra_pkg.sv
// Purpose: Shared constants for the synthesizer register bank and auxiliary port
// Assumes: 32-bit open-style serial word, 24 data bits, 5 address bits, 3 chip bits
// Notes:   Offsets are register indices on the serial port
package pcra_pkg;

    // ************************************************************
    // Serial word layout
    // ************************************************************
    localparam int          WORD_BITS      = 32;
    localparam int          DATA_BITS      = 24;
    localparam int          DATA_LSB       = 8;
    localparam int          ADDR_MSB       = 7;
    localparam int          ADDR_LSB       = 3;
    localparam int          CHIP_MSB       = 2;
    localparam int          SWRST_BIT      = 5;

    // ************************************************************
    // Register offsets
    // ************************************************************
    localparam logic [4:0]  OFS_ID_PTR     = 5'h00;
    localparam logic [4:0]  OFS_POWER      = 5'h01;
    localparam logic [4:0]  OFS_REFDIV     = 5'h02;
    localparam logic [4:0]  OFS_INTDIV     = 5'h03;
    localparam logic [4:0]  OFS_FRACDIV    = 5'h04;
    localparam logic [4:0]  OFS_AUXWORD    = 5'h05;

    // ************************************************************
    // Field positions and reset values
    // ************************************************************
    localparam int          PWR_PIN_SEL    = 0;
    localparam int          PWR_SPI_EN     = 1;
    localparam int          PWR_KEEP_LSB   = 2;
    localparam int          KEEP_COUNT     = 6;
    localparam logic [8:0]  RST_POWER      = 9'h002;
    localparam logic [13:0] RST_REFDIV     = 14'h0001;
    localparam logic [18:0] RST_INTDIV     = 19'h000C8;
    localparam logic [23:0] RST_FRACDIV    = 24'h000000;
    localparam logic [15:0] RST_AUXWORD    = 16'h0000;
    localparam logic [4:0]  RST_READPTR    = 5'h00;

    // ************************************************************
    // Auxiliary port timing, in phase-detector cycles
    // ************************************************************
    localparam int          AUX_LEAD_CYC   = 2;
    localparam int          AUX_DATA_CYC   = 16;
    localparam int          AUX_TAIL_CYC   = 2;
    localparam int          AUX_TOTAL_CYC  = 20;

    typedef enum logic [1:0] {
        AUX_IDLE = 2'b00,
        AUX_LEAD = 2'b01,
        AUX_DATA = 2'b11,
        AUX_TAIL = 2'b10
    } pcra_aux_state_t;

endpackage

//--- sim/pcra_host_model.sv
// Purpose: Host controller driving the open-style serial port
// Assumes: 125 ns link clock that stands still between frames
// Notes:   Idle data line shows the inverse of the last bit
`timescale 1ns/10ps
module pcra_host_model (
    output logic      serialClk,
    output logic      serialDataIn,
    output logic      serialSelectStrobe,
    input  wire logic lockStatusSerialOut
);
    // ************************************************************
    // Frame engine
    // ************************************************************
    initial begin
        serialClk = 1'b0;
        serialDataIn = 1'b0;
        serialSelectStrobe = 1'b0;
    end

    // Data, address, chip bits MSB first, commit on strobe rise
    task automatic frame(input logic [31:0] w, output logic [23:0] rd);
        for (int i = 0; i < 32; i++) begin
            serialDataIn = w[31-i];
            #62.5 serialClk = 1'b1;
            #62.5 serialClk = 1'b0;
            // Read-back taken on the falling edge, no strobe needed
            if (i < 24) rd[23-i] = lockStatusSerialOut;
        end
        serialDataIn = ~w[0];
        #20 serialSelectStrobe = 1'b1;
        #40 serialSelectStrobe = 1'b0;
        #100;
    endtask
endmodule

//--- sim/pcra_regs_aux_bench.sv
// Purpose: Self-checking bench for the register bank and auxiliary port
// Assumes: Phase-detector clock 80 ns, well below ref_clk/8
// Notes:   Random register values from a fixed seed
`timescale 1ns/10ps
module pcra_regs_aux_bench;
    import pcra_pkg::*;
    localparam logic [23:0] ID = 24'h3C5A96; // Arbitrary value
    logic        ref_clk = 0, rst_n = 0, pfdClk = 0, lockDetectIn = 0, externalEnablePin = 0;
    logic        serialClk, serialDataIn, serialSelectStrobe, lockStatusSerialOut, lockStatusSerialOutOe;
    logic        auxSerialClk, auxiliaryDataPin, auxSerialStrobe, chipEnable;
    logic [5:0]  blockPowered;
    logic [13:0] refDivide;
    logic [18:0] intDivide;
    logic [23:0] fracDivide, rd, d;
    logic [15:0] auxSh;
    logic [4:0]  a;
    int          errTotal = 0, numChecks = 0, cyc = 0, auxCnt = 0, stbCnt = 0;

    pcra_regs_aux #(.ID_WORD(ID), .CHIP_ADDR(3'h0), .SYNC_N(5)) dut (.ref_clk(ref_clk), .rst_n(rst_n),
        .serialClk(serialClk), .serialDataIn(serialDataIn), .serialSelectStrobe(serialSelectStrobe),
        .lockStatusSerialOut(lockStatusSerialOut), .lockStatusSerialOutOe(lockStatusSerialOutOe),
        .lockDetectIn(lockDetectIn), .externalEnablePin(externalEnablePin), .pfdClk(pfdClk),
        .auxSerialClk(auxSerialClk), .auxiliaryDataPin(auxiliaryDataPin), .auxSerialStrobe(auxSerialStrobe),
        .chipEnable(chipEnable), .blockPowered(blockPowered), .refDivide(refDivide),
        .intDivide(intDivide), .fracDivide(fracDivide));
    pcra_host_model host (.serialClk(serialClk), .serialDataIn(serialDataIn),
        .serialSelectStrobe(serialSelectStrobe), .lockStatusSerialOut(lockStatusSerialOut));

    // ************************************************************
    // Clocks, timeout, auxiliary port monitor
    // ************************************************************
    always #2 ref_clk = ~ref_clk;
    always #40 pfdClk = ~pfdClk;
    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == 75000) begin
            errTotal++;
            stopTest();
        end
    end
    always @(posedge auxSerialClk) begin
        auxSh = {auxSh[14:0], auxiliaryDataPin};
        auxCnt++;
    end
    always @(posedge auxSerialStrobe) stbCnt++;

    // ************************************************************
    // Helpers and expectations
    // ************************************************************
    task automatic check(input logic [23:0] seen, input logic [23:0] exp, input string msg);
        numChecks++;
        if (seen !== exp) begin
            errTotal++;
            $display("[FAIL] %0t %s seen %h want %h", $time, msg, seen, exp);
        end
    endtask
    task automatic wr(input logic [4:0] ad, input logic [23:0] dt, input logic [2:0] c = 3'h0);
        host.frame({dt, ad, c}, rd);
    endtask
    // Two-frame read: pointer first, then the word comes back
    task automatic rdReg(input logic [4:0] ad);
        wr(OFS_ID_PTR, {19'h0, ad});
        wr(OFS_ID_PTR, {19'h0, ad});
    endtask
    function automatic logic [23:0] mask(input logic [4:0] ad, input logic [23:0] dt);
        case (ad)
            5'h00: return ID;
            5'h01: return dt & 24'h0001FF;
            5'h02: return dt & 24'h003FFF;
            5'h03: return dt & 24'h07FFFF;
            5'h04: return dt;
            5'h05: return dt & 24'h00FFFF;
            default: return 24'h000000;
        endcase
    endfunction
    function automatic logic [23:0] pwrExp(input logic [8:0] r, input logic pin);
        logic ce;
        ce = r[0] ? pin : r[1];
        return {17'h0, ce, r[7:2] | {6{ce}}};
    endfunction
    task automatic stopTest();
        $display("errors %0d checks %0d", errTotal, numChecks);
        if (errTotal == 0 && numChecks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    // ************************************************************
    // Main sequence
    // ************************************************************
    initial begin
        void'($urandom(29));
        repeat (12) @(posedge ref_clk);
        #1 rst_n = 1'b1;
        repeat (8) @(posedge ref_clk);
        #1 check({17'h0, chipEnable, blockPowered}, pwrExp(RST_POWER, 1'b0), "power default");
        check({23'h0, lockStatusSerialOutOe}, 24'h000001, "output enable");
        check({refDivide, intDivide[9:0]}, {RST_REFDIV, RST_INTDIV[9:0]}, "divide default");
        wr(OFS_ID_PTR, 24'hFFFFC0);
        wr(OFS_ID_PTR, 24'hFFFFC0);
        check(rd, ID, "id word");
        for (int i = 0; i < 6; i++) begin
            a = 5'(1 + $urandom % 5);
            d = 24'($urandom);
            if (a == OFS_INTDIV) d = 24'(16 + $urandom % 524269);
            wr(a, d);
            rdReg(a);
            check(rd, mask(a, d), "read back");
        end
        wr(OFS_FRACDIV, 24'hA5C3F0);
        check(fracDivide, 24'hA5C3F0, "frac port");
        for (int i = 0; i < 5; i++) begin
            d = 24'($urandom);
            if (i < 4) d[1:0] = 2'(i);
            wr(OFS_POWER, d);
            for (int j = 0; j < 2; j++) begin
                @(posedge ref_clk) #1 externalEnablePin = j[0];
                repeat (8) @(posedge ref_clk);
                #1 check({17'h0, chipEnable, blockPowered}, pwrExp(d[8:0], j[0]), "power");
            end
        end
        d = 24'($urandom);
        wr(OFS_AUXWORD, d);
        auxCnt = 0;
        stbCnt = 0;
        wr(OFS_INTDIV, 24'h000014);
        #2000 check({auxSh, 8'(auxCnt)}, {d[15:0], 8'h10}, "aux word");
        check(24'(stbCnt), 24'h000001, "aux strobe");
        check(24'(intDivide), 24'h000014, "int port");
        wr(OFS_REFDIV, 24'h001234); // Reference buffer enable lives elsewhere
        wr(OFS_REFDIV, 24'h002BCD, 3'h5);
        check(24'(refDivide), 24'h001234, "chip address");
        rdReg(5'h1F);
        check(rd, 24'h0, "unmapped");
        for (int j = 0; j < 2; j++) begin
            @(posedge ref_clk) #1 lockDetectIn = j[0];
            repeat (4) @(posedge ref_clk);
            #1 check({23'h0, lockStatusSerialOut}, {23'h0, j[0]}, "lock status");
        end
        wr(OFS_ID_PTR, 24'h000020);
        check({refDivide, intDivide[9:0]}, {RST_REFDIV, RST_INTDIV[9:0]}, "soft reset");
        check({17'h0, chipEnable, blockPowered}, pwrExp(RST_POWER, 1'b0), "soft power");
        rdReg(OFS_AUXWORD);
        check(rd, 24'h0, "soft aux");
        rdReg(OFS_ID_PTR);
        check(rd, ID, "id after strobe");
        stopTest();
    end
endmodule
